// ==== jlsc_consts.vh ====
// Constants for the link synchronisation controller: offsets, fields, reset values and counts.
`ifndef JLSC_CONSTS_VH
`define JLSC_CONSTS_VH

`define JLSC_ADDR_W        8
`define JLSC_LANES         4
`define JLSC_CNT_W         12

`define JLSC_OFF_CTRL      8'h00
`define JLSC_OFF_CFG       8'h04
`define JLSC_OFF_IRQ_EN    8'h08
`define JLSC_OFF_TX_STAT   8'h0c
`define JLSC_OFF_TX_ADJ    8'h10
`define JLSC_OFF_RX_ERR_A  8'h14
`define JLSC_OFF_RX_ERR_B  8'h18
`define JLSC_OFF_RX_STAT   8'h1c

`define JLSC_CTRL_LANE_SYNC   0
`define JLSC_CTRL_REINIT_DIS  1
`define JLSC_CTRL_SC_LO       2
`define JLSC_CTRL_SC_HI       3
`define JLSC_CTRL_TX_SWREQ    4
`define JLSC_CTRL_RX_SWREQ    5
`define JLSC_CTRL_TX_HOLD     6
`define JLSC_CTRL_RX_HOLD     7
`define JLSC_CTRL_RST         8'hc1

`define JLSC_CFG_RST          32'h0f03_0100

`define JLSC_IRQ_TX_REINIT    0
`define JLSC_IRQ_TX_ERRREP    1
`define JLSC_IRQ_RX_CGS       2
`define JLSC_IRQ_RX_FRAME     3
`define JLSC_IRQ_RX_LANE      4
`define JLSC_IRQ_EN_RST       5'h00

`define JLSC_K_NEEDED         3'h4
`define JLSC_ILAS_MF          2'h3
`define JLSC_ERR_F1_OCT       10'h004
`define JLSC_REINIT_ADD_OCT   12'h009
`define JLSC_OCT_PER_CYC      16'h0004

`define JLSC_SC0              2'h0
`define JLSC_SC2              2'h2

`endif

// ==== jlsc_conv_model.sv ====
// Converter at the far side: sync request, error pulses and K characters.
`timescale 1ns/1ps
`default_nettype none

module jlsc_conv_model
(
  input  wire logic       i_ref_clk,
  input  wire logic       i_rst_b,
  input  wire logic [7:0] i_frame_f,
  input  wire logic       i_ready,
  input  wire logic       i_err_req,
  input  wire logic       i_adc_on,
  input  wire logic       i_rx_sync_n,
  output logic            o_sync_n,
  output logic [3:0]      o_lane_k
);
  int pulse_cnt;

  // Error pulse lasts two frames, stretched to four frames when F is one.
  always @(posedge i_ref_clk)
  begin
    if (!i_rst_b)
      pulse_cnt <= 0;
    else if (i_err_req)
      pulse_cnt <= (i_frame_f == 8'h01) ? 1 : (2 * i_frame_f + 3) / 4;
    else if (pulse_cnt > 0)
      pulse_cnt <= pulse_cnt - 1;
  end

  assign o_sync_n = i_ready && (pulse_cnt == 0);
  assign o_lane_k = (i_adc_on && !i_rx_sync_n) ? 4'hf : 4'h0;
endmodule
`default_nettype wire

// ==== jlsc_lmfc_cnt.v ====
// Multiframe counter with clear, run enable and wrap pulse.
`timescale 1ns/1ps
`default_nettype none
`include "jlsc_consts.vh"

module jlsc_lmfc_cnt
(
  input  wire                   i_ref_clk,
  input  wire                   i_rst_b,
  input  wire                   i_clear,
  input  wire                   i_run,
  input  wire [`JLSC_CNT_W-1:0] i_max,
  output wire [`JLSC_CNT_W-1:0] o_count,
  output wire                   o_wrap
);

  reg [`JLSC_CNT_W-1:0] count_reg;

  assign o_count = count_reg;
  assign o_wrap  = i_run && !i_clear && (count_reg == i_max);

  // Counts from zero up to the multiframe length minus one, then wraps.
  always @(posedge i_ref_clk)
  begin
    if (!i_rst_b || i_clear)
      count_reg <= {`JLSC_CNT_W{1'b0}};
    else if (i_run)
    begin
      if (count_reg >= i_max)
        count_reg <= {`JLSC_CNT_W{1'b0}};
      else
        count_reg <= count_reg + {{(`JLSC_CNT_W-1){1'b0}}, 1'b1};
    end
  end

endmodule
`default_nettype wire

// ==== jlsc_sync_ctrl.v ====
// Transmit and receive link synchronisation control with its register port.
//
// Behaviour
// - TX multiframe counter (subclass 0 only) and lane alignment wait until every grouped link releases sync.
// - TX filters error pulses from raw sync, outputs it, uses the combined input.
// - RX releases deskewed data only when the buffer release offset is reached.
// - TX reinitialises when sync stays low over five frames plus nine octets.
// - RX requests sync on code group loss, frame or lane alignment error.
// - Both cores accept a software reinitialisation; RX then asserts sync.
// - TX software reinit sends K characters until the receiver asserts sync.
// - One control bit suppresses every hardware reinitialisation.
// - Hardware reinitialisation raises an interrupt when that error's enable is set.
// - Configuration is written while link reset holds; release starts operation.
// - Subclass 0 TX leaves code group sync on release, to lane alignment or data.
// - Subclass 1 and 2 TX need one sampled reference rising edge first.
// - Subclass 2 TX measures release phase; software adjust values go out in alignment.
// - RX holds sync low throughout reset.
// - RX releases sync only after enough K characters.
// - Subclass 1 and 2 RX also need a reference edge; it is timing master.
// - TX detects error reports of two frames, four when F is one, and interrupts.
// - Multiframe counter runs zero to F times K over four minus one.
// - Subclass 2 flags off-boundary release; direction zero at or below half count.
//
// Implementation choices: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "jlsc_consts.vh"

module jlsc_sync_ctrl
(
  input  wire                    i_ref_clk,
  input  wire                    i_rst_b,
  input  wire [`JLSC_ADDR_W-1:0] i_addr,
  input  wire [31:0]             i_wdata,
  input  wire                    i_wr,
  input  wire                    i_rd,
  output reg  [31:0]             o_rdata,
  input  wire                    i_sysref,
  input  wire                    i_tx_sync_n,
  input  wire                    i_tx_mdev_sync_n,
  output wire                    o_tx_dev_sync_n,
  output wire [1:0]              o_tx_phase,
  output wire                    o_tx_lmfc_wrap,
  output wire                    o_tx_ilas_phadj,
  output wire                    o_tx_ilas_adjdir,
  output wire [7:0]              o_tx_ilas_adjcnt,
  output wire                    o_tx_irq,
  input  wire [`JLSC_LANES-1:0]  i_rx_lane_k,
  input  wire [`JLSC_LANES-1:0]  i_rx_lane_err,
  input  wire                    i_rx_frame_err,
  input  wire                    i_rx_lane_align_err,
  input  wire                    i_rx_lanes_arrived,
  output wire                    o_rx_sync_n,
  output wire                    o_rx_data_release,
  output wire                    o_rx_irq
);

  localparam [1:0] TX_CGS   = 2'h0;
  localparam [1:0] TX_ILAS  = 2'h1;
  localparam [1:0] TX_DATA  = 2'h2;
  localparam [1:0] TX_KWAIT = 2'h3;
  localparam       RX_INIT  = 1'b0;
  localparam       RX_DATA  = 1'b1;

  // Turns a write of ones into a clear, while a fresh event keeps its bit set.
  function [7:0] sticky;
    input [7:0] cur;
    input [7:0] set;
    input [7:0] clr;
    begin
      sticky = (cur & ~clr) | set;
    end
  endfunction

  reg  [7:0]             ctrl_reg;
  reg  [31:0]            cfg_reg;
  reg  [4:0]             irq_en_reg;
  reg  [9:0]             tx_adj_reg;
  reg  [7:0]             tx_flags_reg;
  reg  [7:0]             rx_error_status_a_reg;
  reg  [7:0]             rx_error_status_b_reg;
  reg  [1:0]             tx_state_reg;
  reg  [1:0]             tx_state_next;
  reg  [1:0]             ilas_mf_reg;
  reg  [15:0]            tx_low_oct_reg;
  reg                    tx_dev_sync_reg;
  reg                    mdev_q_reg;
  reg                    sysref_q_reg;
  reg                    tx_sref_seen_reg;
  reg                    rx_sref_seen_reg;
  reg                    phadj_reg;
  reg                    adjdir_reg;
  reg  [7:0]             adjcnt_reg;
  reg                    rx_state_reg;
  reg                    rx_sync_reg;
  reg                    rx_release_reg;
  reg  [2:0]             kcnt_reg [0:`JLSC_LANES-1];
  wire [`JLSC_LANES-1:0] lane_ok;
  wire [`JLSC_LANES-1:0] lane_act = cfg_reg[27:24];
  wire [1:0]             sc       = ctrl_reg[`JLSC_CTRL_SC_HI:`JLSC_CTRL_SC_LO];
  wire                   tx_hold  = ctrl_reg[`JLSC_CTRL_TX_HOLD];
  wire                   rx_hold  = ctrl_reg[`JLSC_CTRL_RX_HOLD];
  wire                   hw_dis   = ctrl_reg[`JLSC_CTRL_REINIT_DIS];
  wire [8:0]             f_val    = {1'b0, cfg_reg[7:0]} + 9'h001;
  wire [5:0]             k_val    = {1'b0, cfg_reg[12:8]} + 6'h01;
  wire [14:0]            fk       = f_val * k_val;
  wire [12:0]            mf_len   = fk[14:2];
  wire [12:0]            mf_max13 = mf_len - 13'h0001;
  wire [`JLSC_CNT_W-1:0] mf_max   = mf_max13[`JLSC_CNT_W-1:0];
  wire [9:0]             err_oct  = (f_val == 9'h001) ? `JLSC_ERR_F1_OCT : {f_val, 1'b0};
  wire [11:0]            f5       = {3'h0, f_val} * 12'h005;
  wire [11:0]            rein_oct = f5 + `JLSC_REINIT_ADD_OCT;
  wire                   wr_ctrl  = i_wr && (i_addr == `JLSC_OFF_CTRL);
  wire                   tx_swreq = wr_ctrl && i_wdata[`JLSC_CTRL_TX_SWREQ];
  wire                   rx_swreq = wr_ctrl && i_wdata[`JLSC_CTRL_RX_SWREQ];
  wire                   sref_re  = i_sysref && !sysref_q_reg;
  wire                   long_low = (tx_low_oct_reg > {4'h0, rein_oct});
  wire                   tx_err   = i_tx_sync_n && !long_low && (tx_low_oct_reg >= {6'h00, err_oct});
  wire                   tx_live  = (tx_state_reg == TX_ILAS) || (tx_state_reg == TX_DATA);
  wire                   tx_hwre  = tx_live && long_low && !hw_dis;
  wire                   tx_cnt_clr;
  wire                   tx_wrap;
  wire [`JLSC_CNT_W-1:0] tx_cnt;
  wire                   rx_wrap;
  wire [`JLSC_CNT_W-1:0] rx_cnt;
  wire                   rx_k_ok  = &lane_ok;
  wire [`JLSC_LANES-1:0] lane_bad = i_rx_lane_err & lane_act;
  wire                   rx_cgs_l = (rx_state_reg == RX_DATA) && (|lane_bad);
  wire                   rx_frm_e = (rx_state_reg == RX_DATA) && i_rx_frame_err;
  wire                   rx_ln_e  = (rx_state_reg == RX_DATA) && i_rx_lane_align_err;
  wire                   rx_hwre  = (rx_cgs_l || rx_frm_e || rx_ln_e) && !hw_dis;
  wire [7:0]             tx_set   = {6'h00, tx_err, tx_hwre};
  wire [7:0]             rxa_set  = {5'h00, rx_ln_e, rx_frm_e, rx_cgs_l};
  wire [7:0]             rxb_set  = {4'h0, lane_bad & {`JLSC_LANES{rx_state_reg == RX_DATA}}};

  ////////////////////////////////////////////////////////////////////////////////
  // Register port.

  always @(posedge i_ref_clk)
  begin
    if (!i_rst_b)
    begin
      ctrl_reg              <= `JLSC_CTRL_RST;
      cfg_reg               <= `JLSC_CFG_RST;
      irq_en_reg            <= `JLSC_IRQ_EN_RST;
      tx_adj_reg            <= 10'h000;
      tx_flags_reg          <= 8'h00;
      rx_error_status_a_reg <= 8'h00;
      rx_error_status_b_reg <= 8'h00;
      o_rdata               <= 32'h0000_0000;
    end
    else
    begin
      if (wr_ctrl)
        ctrl_reg <= {i_wdata[7:6], 2'h0, i_wdata[3:0]};
      if (i_wr && (i_addr == `JLSC_OFF_CFG) && tx_hold && rx_hold)
        cfg_reg <= i_wdata;
      if (i_wr && (i_addr == `JLSC_OFF_IRQ_EN))
        irq_en_reg <= i_wdata[4:0];
      if (i_wr && (i_addr == `JLSC_OFF_TX_ADJ))
        tx_adj_reg <= {i_wdata[15:8], i_wdata[1:0]};
      tx_flags_reg <= sticky(tx_flags_reg, tx_set,
                             (i_wr && i_addr == `JLSC_OFF_TX_STAT) ? i_wdata[7:0] : 8'h00);
      rx_error_status_a_reg <= sticky(rx_error_status_a_reg, rxa_set,
                                      (i_wr && i_addr == `JLSC_OFF_RX_ERR_A) ? i_wdata[7:0] : 8'h00);
      rx_error_status_b_reg <= sticky(rx_error_status_b_reg, rxb_set,
                                      (i_wr && i_addr == `JLSC_OFF_RX_ERR_B) ? i_wdata[7:0] : 8'h00);
      o_rdata <= 32'h0000_0000;
      if (i_rd)
      begin
        case (i_addr)
          `JLSC_OFF_CTRL:     o_rdata <= {24'h000000, ctrl_reg};
          `JLSC_OFF_CFG:      o_rdata <= cfg_reg;
          `JLSC_OFF_IRQ_EN:   o_rdata <= {27'h0000000, irq_en_reg};
          `JLSC_OFF_TX_STAT:  o_rdata <= {8'h00, adjcnt_reg, 3'h0, tx_sref_seen_reg, adjdir_reg, phadj_reg,
                                          tx_state_reg, 6'h00, tx_flags_reg[1:0]};
          `JLSC_OFF_TX_ADJ:   o_rdata <= {16'h0000, tx_adj_reg[9:2], 6'h00, tx_adj_reg[1:0]};
          `JLSC_OFF_RX_ERR_A: o_rdata <= {24'h000000, rx_error_status_a_reg};
          `JLSC_OFF_RX_ERR_B: o_rdata <= {24'h000000, rx_error_status_b_reg};
          `JLSC_OFF_RX_STAT:  o_rdata <= {28'h0000000, rx_release_reg, rx_sref_seen_reg,
                                          rx_sync_reg, rx_state_reg};
          default:            o_rdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Transmit sync filter, error report and reference edge tracking.

  always @(posedge i_ref_clk)
  begin
    if (!i_rst_b || tx_hold)
    begin
      tx_low_oct_reg   <= 16'h0000;
      tx_dev_sync_reg  <= 1'b0;
      mdev_q_reg       <= 1'b0;
      sysref_q_reg     <= 1'b0;
      tx_sref_seen_reg <= 1'b0;
    end
    else
    begin
      if (i_tx_sync_n)
        tx_low_oct_reg <= 16'h0000;
      else if (tx_low_oct_reg < 16'hfff0)
        tx_low_oct_reg <= tx_low_oct_reg + `JLSC_OCT_PER_CYC;
      tx_dev_sync_reg <= !(long_low && !i_tx_sync_n);
      mdev_q_reg      <= i_tx_mdev_sync_n;
      sysref_q_reg    <= i_sysref;
      if (sref_re)
        tx_sref_seen_reg <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Transmit state machine and subclass 2 phase measurement.

  assign tx_cnt_clr = ((sc == `JLSC_SC0) && (tx_state_reg == TX_CGS) && !i_tx_mdev_sync_n) ||
                      ((sc == 2'h1) && sref_re);

  jlsc_lmfc_cnt u_tx_lmfc
  (
    .i_ref_clk (i_ref_clk),
    .i_rst_b   (i_rst_b && !tx_hold),
    .i_clear   (tx_cnt_clr),
    .i_run     (1'b1),
    .i_max     (mf_max),
    .o_count   (tx_cnt),
    .o_wrap    (tx_wrap)
  );

  always @*
  begin
    tx_state_next = tx_state_reg;
    case (tx_state_reg)
      TX_CGS:
      begin
        if (i_tx_mdev_sync_n && ((sc == `JLSC_SC0) || (tx_sref_seen_reg && tx_wrap)))
          tx_state_next = ctrl_reg[`JLSC_CTRL_LANE_SYNC] ? TX_ILAS : TX_DATA;
      end
      TX_ILAS:
      begin
        if (tx_wrap && (ilas_mf_reg == `JLSC_ILAS_MF))
          tx_state_next = TX_DATA;
      end
      TX_DATA:
        tx_state_next = TX_DATA;
      TX_KWAIT:
      begin
        if (!i_tx_mdev_sync_n)
          tx_state_next = TX_CGS;
      end
      default:
        tx_state_next = TX_CGS;
    endcase
    if (tx_hwre)
      tx_state_next = TX_CGS;
    if (tx_swreq)
      tx_state_next = TX_KWAIT;
  end

  always @(posedge i_ref_clk)
  begin
    if (!i_rst_b || tx_hold)
    begin
      tx_state_reg <= TX_CGS;
      ilas_mf_reg  <= 2'h0;
      phadj_reg    <= 1'b0;
      adjdir_reg   <= 1'b0;
      adjcnt_reg   <= 8'h00;
    end
    else
    begin
      tx_state_reg <= tx_state_next;
      if (tx_state_reg != TX_ILAS)
        ilas_mf_reg <= 2'h0;
      else if (tx_wrap)
        ilas_mf_reg <= ilas_mf_reg + 2'h1;
      if ((sc == `JLSC_SC2) && (tx_state_reg == TX_CGS) && i_tx_mdev_sync_n && !mdev_q_reg)
      begin
        if (tx_cnt == {`JLSC_CNT_W{1'b0}})
          phadj_reg <= 1'b0;
        else
        begin
          phadj_reg <= 1'b1;
          if ({tx_cnt, 1'b0} <= mf_len)
          begin
            adjdir_reg <= 1'b0;
            adjcnt_reg <= tx_cnt[7:0];
          end
          else
          begin
            adjdir_reg <= 1'b1;
            adjcnt_reg <= mf_len[7:0] - tx_cnt[7:0];
          end
        end
      end
    end
  end

  assign o_tx_dev_sync_n  = tx_dev_sync_reg;
  assign o_tx_phase       = (tx_state_reg == TX_KWAIT) ? TX_CGS : tx_state_reg;
  assign o_tx_lmfc_wrap   = tx_wrap;
  assign o_tx_ilas_phadj  = tx_adj_reg[0];
  assign o_tx_ilas_adjdir = tx_adj_reg[1];
  assign o_tx_ilas_adjcnt = tx_adj_reg[9:2];
  assign o_tx_irq         = |(tx_flags_reg[1:0] & irq_en_reg[1:0]);

  ////////////////////////////////////////////////////////////////////////////////
  // Receive K character counting per lane.

  genvar g;
  generate
    for (g = 0; g < `JLSC_LANES; g = g + 1)
    begin : g_lane
      always @(posedge i_ref_clk)
      begin
        if (!i_rst_b || rx_hold || i_rx_lane_err[g] || !i_rx_lane_k[g])
          kcnt_reg[g] <= 3'h0;
        else if (kcnt_reg[g] != `JLSC_K_NEEDED)
          kcnt_reg[g] <= kcnt_reg[g] + 3'h1;
      end
      assign lane_ok[g] = !lane_act[g] || (kcnt_reg[g] == `JLSC_K_NEEDED);
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // Receive sync request and buffer release.

  jlsc_lmfc_cnt u_rx_lmfc
  (
    .i_ref_clk (i_ref_clk),
    .i_rst_b   (i_rst_b && !rx_hold),
    .i_clear   ((sc == 2'h1) && sref_re),
    .i_run     (1'b1),
    .i_max     (mf_max),
    .o_count   (rx_cnt),
    .o_wrap    (rx_wrap)
  );

  always @(posedge i_ref_clk)
  begin
    if (!i_rst_b || rx_hold)
    begin
      rx_state_reg     <= RX_INIT;
      rx_sync_reg      <= 1'b0;
      rx_sref_seen_reg <= 1'b0;
      rx_release_reg   <= 1'b0;
    end
    else
    begin
      if (sref_re)
        rx_sref_seen_reg <= 1'b1;
      case (rx_state_reg)
        RX_INIT:
        begin
          rx_release_reg <= 1'b0;
          if (rx_k_ok && ((sc == `JLSC_SC0) || (rx_sref_seen_reg && rx_wrap)))
          begin
            rx_state_reg <= RX_DATA;
            rx_sync_reg  <= 1'b1;
          end
        end
        RX_DATA:
        begin
          if (rx_hwre || rx_swreq)
          begin
            rx_state_reg   <= RX_INIT;
            rx_sync_reg    <= 1'b0;
            rx_release_reg <= 1'b0;
          end
          else if (i_rx_lanes_arrived && (rx_cnt == {4'h0, cfg_reg[23:16]}))
            rx_release_reg <= 1'b1;
        end
        default:
          rx_state_reg <= RX_INIT;
      endcase
    end
  end

  assign o_rx_sync_n       = rx_sync_reg;
  assign o_rx_data_release = rx_release_reg;
  assign o_rx_irq          = |(rx_error_status_a_reg[2:0] & irq_en_reg[4:2]);

endmodule
`default_nettype wire

// ==== jlsc_sync_ctrl_asserts.sv ====
// Concurrent checks on the ports of the link synchronisation controller.
`timescale 1ns/1ps
`default_nettype none

module jlsc_sync_ctrl_chk
(
  input wire logic        i_ref_clk,
  input wire logic        i_rst_b,
  input wire logic        i_rd,
  input wire logic        i_wr,
  input wire logic [31:0] o_rdata,
  input wire logic        i_tx_sync_n,
  input wire logic        i_tx_mdev_sync_n,
  input wire logic        o_tx_dev_sync_n,
  input wire logic [1:0]  o_tx_phase,
  input wire logic [3:0]  i_rx_lane_k,
  input wire logic [3:0]  i_rx_lane_err,
  input wire logic        i_rx_frame_err,
  input wire logic        i_rx_lane_align_err,
  input wire logic        i_rx_lanes_arrived,
  input wire logic        o_rx_sync_n,
  input wire logic        o_rx_data_release,
  input wire logic        o_rx_irq
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_b);
  wire rx_err = (|i_rx_lane_err) || i_rx_frame_err || i_rx_lane_align_err;

  a_rdata_quiet: assert property (!$past(i_rd) |-> o_rdata == 32'h0)
    else $error("read data outside its answer cycle");
  a_rx_sync_reset: assert property ($rose(i_rst_b) |-> !o_rx_sync_n)
    else $error("rx sync not low out of reset");
  a_tx_filter: assert property ($fell(o_tx_dev_sync_n) |-> !$past(i_tx_sync_n, 2) && !$past(i_tx_sync_n, 3))
    else $error("filtered sync fell on a short pulse");
  a_ilas_entry: assert property ($changed(o_tx_phase) && o_tx_phase == 2'h1 |-> $past(o_tx_phase) == 2'h0)
    else $error("lane alignment not entered from code group sync");
  a_cgs_hold: assert property (o_tx_phase == 2'h0 && !i_tx_mdev_sync_n |=> o_tx_phase == 2'h0)
    else $error("tx left code group sync while combined sync low");
  a_rx_k_release: assert property ($rose(o_rx_sync_n) |-> &($past(i_rx_lane_k, 2)) && $past(i_rx_lane_err, 2) == 4'h0)
    else $error("rx sync released without clean K");
  a_rx_err_drop: assert property (o_rx_sync_n && rx_err |-> ##[1:3] !o_rx_sync_n)
    else $error("rx sync not asserted after error");
  a_release_cause: assert property ($rose(o_rx_data_release) |-> $past(i_rx_lanes_arrived) && o_rx_sync_n)
    else $error("data released before lanes arrived");
  a_rx_irq_cause: assert property ($rose(o_rx_irq) |-> $past(rx_err) || $past(rx_err, 2) || $past(rx_err, 3) || $past(i_wr))
    else $error("rx interrupt without cause");

  c_rx_up: cover property ($rose(o_rx_sync_n));
  c_tx_drop: cover property ($fell(o_tx_dev_sync_n));
  c_tx_reinit: cover property (o_tx_phase == 2'h2 ##1 o_tx_phase != 2'h2);
endmodule
`default_nettype wire

// ==== tb_jesd_link_sync_control.sv ====
// Self-checking bench for the link synchronisation controller.
`timescale 1ns/1ps
`default_nettype none

module tb_jesd_link_sync_control;
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic        sysref = 1'b0;
  logic        ready = 1'b0;
  logic        peer_n = 1'b0;
  logic        err_req = 1'b0;
  logic        adc_on = 1'b0;
  logic [3:0]  lane_err = 4'h0;
  logic        frame_err = 1'b0;
  logic        align_err = 1'b0;
  logic        arrived = 1'b0;
  wire  [31:0] rdata;
  wire  [1:0]  phase;
  wire  [7:0]  adjcnt;
  wire  [3:0]  lane_k;
  wire         sync_n, dev_n, wrap, phadj, adjdir, tx_irq, rx_sync_n, rel, rx_irq;
  wire         mdev_n = dev_n & peer_n;
  int          num_errors = 0;
  int          check_count = 0;
  int          cycles = 0;
  int          n, k;
  logic [31:0] got;
  logic [31:0] lfsr = 32'h6863;
  logic [31:0] mdl [0:7] = '{32'hc1, 32'h0f030100, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
  logic [31:0] wmask [0:7] = '{32'hcf, 32'h0fff1fff, 32'h1f, 32'h0, 32'hff03, 32'h0, 32'h0, 32'h0};

  jlsc_sync_ctrl u_jlsc_sync_ctrl
  (
    .i_ref_clk(clk), .i_rst_b(rst_b), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
    .o_rdata(rdata), .i_sysref(sysref), .i_tx_sync_n(sync_n), .i_tx_mdev_sync_n(mdev_n),
    .o_tx_dev_sync_n(dev_n), .o_tx_phase(phase), .o_tx_lmfc_wrap(wrap), .o_tx_ilas_phadj(phadj),
    .o_tx_ilas_adjdir(adjdir), .o_tx_ilas_adjcnt(adjcnt), .o_tx_irq(tx_irq), .i_rx_lane_k(lane_k),
    .i_rx_lane_err(lane_err), .i_rx_frame_err(frame_err), .i_rx_lane_align_err(align_err),
    .i_rx_lanes_arrived(arrived), .o_rx_sync_n(rx_sync_n), .o_rx_data_release(rel), .o_rx_irq(rx_irq)
  );

  jlsc_conv_model u_jlsc_conv_model
  (
    .i_ref_clk(clk), .i_rst_b(rst_b), .i_frame_f(8'h04), .i_ready(ready), .i_err_req(err_req),
    .i_adc_on(adc_on), .i_rx_sync_n(rx_sync_n), .o_sync_n(sync_n), .o_lane_k(lane_k)
  );

  always #4 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    lfsr_next = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e)
    begin
      num_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic step(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    mdl[a[4:2]] = d & wmask[a[4:2]];
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [31:0] g);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    g = rdata;
  endtask

  task automatic rd_mdl(input logic [7:0] a);
    rd_reg(a, got);
    chk(got, mdl[a[4:2]]);
  endtask

  task automatic wait_data();
    for (n = 0; n < 200 && phase !== 2'h2; n++) step(1);
    chk(32'(phase), 32'h2);
  endtask

  task automatic done(input string s);
    $display("test %s done", s);
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      num_errors++;
      final_report();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    rd_mdl(8'h00);
    rd_mdl(8'h04);
    rd_mdl(8'h08);
    rd_reg(8'h20, got);
    chk(got, 32'h0);
    chk(32'(rx_sync_n), 32'h0);
    wr_reg(8'h04, 32'h0f020703);
    rd_mdl(8'h04);
    wr_reg(8'h08, 32'h1f);
    for (k = 0; k < 3; k++)
    begin
      lfsr = lfsr_next(lfsr);
      wr_reg(8'h10, lfsr);
      step(1);
      chk({22'h0, adjcnt, adjdir, phadj}, {22'h0, lfsr[15:8], lfsr[1:0]});
      rd_mdl(8'h10);
    end
    wr_reg(8'h00, 32'h01);
    done("registers");
    ready <= 1'b1;
    step(20);
    chk(32'(phase), 32'h0);
    peer_n <= 1'b1;
    for (n = 0; n < 50 && phase !== 2'h1; n++) step(1);
    chk(32'(phase), 32'h1);
    for (n = 0; n < 50 && wrap !== 1'b1; n++) step(1);
    step(1);
    for (n = 1; n < 50 && wrap !== 1'b1; n++) step(1);
    chk(32'(n), 32'h8);
    wait_data();
    done("tx startup");
    err_req <= 1'b1;
    step(1);
    err_req <= 1'b0;
    for (k = 0; k < 6; k++)
    begin
      step(1);
      chk(32'(dev_n), 32'h1);
    end
    chk(32'(tx_irq), 32'h1);
    wr_reg(8'h08, 32'h1d);
    wr_reg(8'h0c, 32'h3);
    step(1);
    chk(32'(tx_irq), 32'h0);
    ready <= 1'b0;
    step(12);
    chk(32'(dev_n), 32'h0);
    rd_reg(8'h0c, got);
    chk(32'(got[0]), 32'h1);
    chk(32'(tx_irq), 32'h1);
    chk(32'(phase), 32'h0);
    ready <= 1'b1;
    wait_data();
    wr_reg(8'h00, 32'h03);
    wr_reg(8'h0c, 32'h3);
    ready <= 1'b0;
    step(12);
    rd_reg(8'h0c, got);
    chk(32'(got[1:0]), 32'h0);
    chk(32'(phase), 32'h2);
    ready <= 1'b1;
    wr_reg(8'h00, 32'h01);
    done("tx reinit");
    step(4);
    wr_reg(8'h00, 32'h11);
    step(2);
    rd_reg(8'h0c, got);
    chk(32'(got[9:8]), 32'h3);
    rd_mdl(8'h00);
    ready <= 1'b0;
    step(12);
    rd_reg(8'h0c, got);
    chk(32'(got[9:8]), 32'h0);
    ready <= 1'b1;
    wait_data();
    done("tx software reinit");
    chk(32'(rx_sync_n), 32'h0);
    adc_on <= 1'b1;
    lane_err <= 4'h4;
    step(1);
    lane_err <= 4'h0;
    step(4);
    chk(32'(rx_sync_n), 32'h0);
    for (n = 0; n < 4 && rx_sync_n !== 1'b1; n++) step(1);
    chk(32'(rx_sync_n), 32'h1);
    step(5);
    chk(32'(rel), 32'h0);
    arrived <= 1'b1;
    for (n = 0; n < 20 && rel !== 1'b1; n++) step(1);
    chk(32'(rel), 32'h1);
    for (k = 0; k < 3; k++)
    begin
      wr_reg(8'h14, 32'h7);
      for (n = 0; n < 40 && rx_sync_n !== 1'b1; n++) step(1);
      step(3);
      lane_err <= (k == 0) ? 4'h1 : 4'h0;
      frame_err <= (k == 1);
      align_err <= (k == 2);
      step(1);
      lane_err <= 4'h0;
      frame_err <= 1'b0;
      align_err <= 1'b0;
      step(3);
      chk(32'(rx_sync_n), 32'h0);
      rd_reg(8'h14, got);
      chk(got & 32'h7, 32'h1 << k);
      chk(32'(rx_irq), 32'h1);
    end
    for (n = 0; n < 40 && rx_sync_n !== 1'b1; n++) step(1);
    wr_reg(8'h00, 32'h21);
    step(2);
    chk(32'(rx_sync_n), 32'h0);
    done("rx link");
    wr_reg(8'h00, 32'h35);
    ready <= 1'b0;
    step(12);
    ready <= 1'b1;
    step(40);
    chk(32'(phase), 32'h0);
    chk(32'(rx_sync_n), 32'h0);
    sysref <= 1'b1;
    step(1);
    sysref <= 1'b0;
    for (n = 0; n < 80 && (phase === 2'h0 || rx_sync_n !== 1'b1); n++) step(1);
    chk(32'(phase === 2'h0), 32'h0);
    chk(32'(rx_sync_n), 32'h1);
    done("subclass one");
    sysref <= 1'b1;
    step(1);
    sysref <= 1'b0;
    wr_reg(8'h00, 32'h19);
    ready <= 1'b0;
    step(12);
    ready <= 1'b1;
    wait_data();
    rd_reg(8'h0c, got);
    chk(32'(got[23:16] <= 8'h04), 32'h1);
    done("subclass two");
    final_report();
  end
endmodule

bind jlsc_sync_ctrl jlsc_sync_ctrl_chk u_jlsc_sync_ctrl_chk
(
  .i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .i_rd(i_rd), .i_wr(i_wr), .o_rdata(o_rdata),
  .i_tx_sync_n(i_tx_sync_n), .i_tx_mdev_sync_n(i_tx_mdev_sync_n), .o_tx_dev_sync_n(o_tx_dev_sync_n),
  .o_tx_phase(o_tx_phase), .i_rx_lane_k(i_rx_lane_k), .i_rx_lane_err(i_rx_lane_err),
  .i_rx_frame_err(i_rx_frame_err), .i_rx_lane_align_err(i_rx_lane_align_err),
  .i_rx_lanes_arrived(i_rx_lanes_arrived), .o_rx_sync_n(o_rx_sync_n),
  .o_rx_data_release(o_rx_data_release), .o_rx_irq(o_rx_irq)
);
`default_nettype wire
